/* design/tcc_consts.svh */
/*
 * Offsets, field positions, reset values and widths of the
 * three-channel timer/counter block.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// register offsets inside a channel window, channel window stride, block register offsets
`define TCC_CH_STRIDE 8'h40
`define TCC_OFS_CCR 6'h00
`define TCC_OFS_CMR 6'h04
`define TCC_OFS_CV 6'h10
`define TCC_OFS_RA 6'h14
`define TCC_OFS_RB 6'h18
`define TCC_OFS_RC 6'h1C
`define TCC_OFS_SR 6'h20
`define TCC_OFS_IER 6'h24
`define TCC_OFS_IDR 6'h28
`define TCC_OFS_IMR 6'h2C
`define TCC_OFS_BCR 8'hC0
`define TCC_OFS_BMR 8'hC4

// channel control register bits
`define TCC_CCR_CLOCK_ENABLE_CMD 0
`define TCC_CCR_CLOCK_DISABLE_CMD 1
`define TCC_CCR_SOFTWARE_TRIGGER_BIT 2

// channel mode register fields, common and capture view
`define TCC_CMR_CLKSEL_LO 0
`define TCC_CMR_CLOCK_INVERT_BIT 3
`define TCC_CMR_BURST_LO 4
`define TCC_CMR_LOAD_B_STOP 6
`define TCC_CMR_LOAD_B_DISABLE 7
`define TCC_CMR_TRIGGER_EDGE_FIELD_LO 8
`define TCC_CMR_TRIGGER_SOURCE_BIT 10
`define TCC_CMR_COMPARE_C_TRIGGER 14
`define TCC_CMR_WAVE 15
`define TCC_CMR_LOAD_A_EDGE_LO 16
`define TCC_CMR_LOAD_B_EDGE_LO 18
// waveform view of the same register
`define TCC_CMR_COMPARE_C_STOP 6
`define TCC_CMR_COMPARE_C_DISABLE 7
`define TCC_CMR_EEVT_LO 10
`define TCC_CMR_EXTERNAL_EVENT_TRIGGER_ENABLE 12
`define TCC_CMR_WIDTH 20
`define TCC_CMR_RESET 20'h00000

// status register bits
`define TCC_SR_COUNTER_OVERFLOW_FLAG 0
`define TCC_SR_LOAD_OVERRUN_FLAG 1
`define TCC_SR_CPCS 4
`define TCC_SR_LDRAS 5
`define TCC_SR_LDRBS 6
`define TCC_SR_ETRGS 7
`define TCC_SR_CLOCK_ENABLED_FLAG 16
`define TCC_SR_FLAGS 8

// block control and block mode registers
`define TCC_BCR_SYNC 0
`define TCC_BMR_WIDTH 6
`define TCC_BMR_RESET 6'h00

`define TCC_CV_RESET 16'h0000
`define TCC_CV_MAX 16'hFFFF
`define TCC_PRESC_WIDTH 7

`endif

/* design/tcc_pkg.sv */
/*
 * Types shared by the timer/counter block.
 * Assumes the constants header sits beside it.
 */
package tcc_pkg;

  typedef logic [15:0] tcc_count_t;

  // edge selection used by capture loads and external triggers
  typedef enum logic [1:0] {
    TCC_EDGE_NONE = 2'h0,
    TCC_EDGE_RISE = 2'h1,
    TCC_EDGE_FALL = 2'h2,
    TCC_EDGE_BOTH = 2'h3
  } tcc_edge_t;

  typedef enum logic [2:0] {
    TCC_CLK_DIV2 = 3'h0,
    TCC_CLK_DIV8 = 3'h1,
    TCC_CLK_DIV32 = 3'h2,
    TCC_CLK_DIV128 = 3'h3,
    TCC_CLK_SLOW = 3'h4,
    TCC_CLK_XC0 = 3'h5,
    TCC_CLK_XC1 = 3'h6,
    TCC_CLK_XC2 = 3'h7
  } tcc_clksel_t;

endpackage : tcc_pkg

/* design/tcc_timer_block.sv */
/*
 * Three-channel 16-bit timer/counter with clock selection, chaining,
 * clock gating, triggers and capture of line A edges into registers A/B.
 * Assumes one master clock sys_clk; pins and slow clock are asynchronous
 * and are filtered here; the register port never waits.
 */
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tcc_timer_block (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clock_enable_cmd,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic slowClock,
  input wire logic [2:0] extClockPin,
  input wire logic [2:0] ioLineAIn,
  output logic [2:0] ioLineAOut,
  output logic [2:0] ioLineAOe,
  input wire logic [2:0] ioLineBIn,
  output logic [2:0] ioLineBOut,
  output logic [2:0] ioLineBOe,
  output logic [2:0] chanIrq
);

  function automatic logic edgeHit(input logic [1:0] sel, input logic rise,
                                   input logic fall);
    edgeHit = (sel[0] & rise) | (sel[1] & fall);
  endfunction : edgeHit

  // asynchronous inputs: slow clock, clock pins, line A, line B
  localparam int NIN = 10;
  logic [NIN-1:0] pinRaw;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic [NIN-1:0] sync3_q;
  logic [NIN-1:0] pinLvl_q;
  logic [NIN-1:0] pinPrev_q;
  assign pinRaw = {ioLineBIn, ioLineAIn, extClockPin, slowClock};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (clock_enable_cmd) begin
      sync1_q <= pinRaw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a bit moves only once stages two and three agree, so a glitch of one
  // cycle never reaches the counters
  genvar gb;
  generate
    for (gb = 0; gb < NIN; gb++) begin : gFilt
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pinLvl_q[gb] <= 1'b0;
          pinPrev_q[gb] <= 1'b0;
        end else if (clock_enable_cmd) begin
          if (sync2_q[gb] == sync3_q[gb]) begin
            pinLvl_q[gb] <= sync3_q[gb];
          end
          pinPrev_q[gb] <= pinLvl_q[gb];
        end
      end
    end
  endgenerate

  logic slowLvl;
  logic [2:0] pinClkLvl;
  logic [2:0] aInLvl;
  logic [2:0] aInRise;
  logic [2:0] aInFall;
  logic [2:0] bInRise;
  logic [2:0] bInFall;
  assign slowLvl = pinLvl_q[0];
  assign pinClkLvl = pinLvl_q[3:1];
  assign aInLvl = pinLvl_q[6:4];
  assign aInRise = pinLvl_q[6:4] & ~pinPrev_q[6:4];
  assign aInFall = ~pinLvl_q[6:4] & pinPrev_q[6:4];
  assign bInRise = pinLvl_q[9:7] & ~pinPrev_q[9:7];
  assign bInFall = ~pinLvl_q[9:7] & pinPrev_q[9:7];

  // prescaler: bit k toggles at master/2^(k+1)
  logic [`TCC_PRESC_WIDTH-1:0] presc_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= '0;
    end else if (clock_enable_cmd) begin
      presc_q <= presc_q + 1'b1;
    end
  end

  logic [3:0] divLvl;
  assign divLvl = {presc_q[6], presc_q[4], presc_q[2], presc_q[0]};

  // block registers
  logic [`TCC_BMR_WIDTH-1:0] bmr_q;
  logic syncPulse;
  logic bmrWr;
  assign bmrWr = regWr && (regAddr == `TCC_OFS_BMR);
  assign syncPulse = regWr && (regAddr == `TCC_OFS_BCR) && regWdata[`TCC_BCR_SYNC];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bmr_q <= `TCC_BMR_RESET;
    end else if (clock_enable_cmd && bmrWr) begin
      bmr_q <= regWdata[`TCC_BMR_WIDTH-1:0];
    end
  end

  // per-channel state
  logic [`TCC_CMR_WIDTH-1:0] cmr_q [3];
  tcc_pkg::tcc_count_t cv_q [3];
  tcc_pkg::tcc_count_t ra_q [3];
  tcc_pkg::tcc_count_t rb_q [3];
  tcc_pkg::tcc_count_t rc_q [3];
  logic [`TCC_SR_FLAGS-1:0] sr_q [3];
  logic [`TCC_SR_FLAGS-1:0] imr_q [3];
  logic [2:0] clkOn_q;
  logic [2:0] lineAOutLvl;
  logic [2:0] gatePrevXc;

  // shared external clock lines: each picks its pin or another line A
  logic [2:0] xc;
  genvar gx;
  generate
    for (gx = 0; gx < 3; gx++) begin : gChain
      localparam int O1 = (gx + 1) % 3;
      localparam int O2 = (gx + 2) % 3;
      logic [1:0] xsel;
      logic lineA1;
      logic lineA2;
      assign xsel = bmr_q[2*gx+1:2*gx];
      assign lineA1 = cmr_q[O1][`TCC_CMR_WAVE] ? lineAOutLvl[O1] : aInLvl[O1];
      assign lineA2 = cmr_q[O2][`TCC_CMR_WAVE] ? lineAOutLvl[O2] : aInLvl[O2];
      always_comb begin
        case (xsel)
          2'h0: xc[gx] = pinClkLvl[gx];
          2'h2: xc[gx] = lineA1;
          2'h3: xc[gx] = lineA2;
          default: xc[gx] = 1'b0;
        endcase
      end
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++) begin : gChan
      localparam logic [1:0] CH = 2'(gc);
      logic chSel;
      logic ccrWr;
      logic cmrWr;
      logic [19:0] cmr;
      logic wave;
      logic [2:0] clkSel;
      logic [1:0] burst;
      logic selLvl;
      logic gateLvl;
      logic gatePrev_q;
      logic tick;
      logic running_q;
      logic trgPend_q;
      logic expectB_q;
      logic raUnread_q;
      logic rbUnread_q;
      logic match_q;
      logic match;
      logic cpcEvt;
      logic extEvt;
      logic extTrg;
      logic software_trigger_bit;
      logic trig;
      logic loadA;
      logic loadB;
      logic stopEvt;
      logic disEvt;
      logic enNow;
      logic counting;
      logic overflow;
      logic srRead;
      logic [`TCC_SR_FLAGS-1:0] setFlags;

      assign chSel = (regAddr[7:6] == CH);
      assign ccrWr = regWr && chSel && (regAddr[5:0] == `TCC_OFS_CCR);
      assign cmrWr = regWr && chSel && (regAddr[5:0] == `TCC_OFS_CMR);
      assign srRead = regRd && chSel && (regAddr[5:0] == `TCC_OFS_SR);
      assign cmr = cmr_q[gc];
      assign wave = cmr[`TCC_CMR_WAVE];
      assign clkSel = cmr[`TCC_CMR_CLKSEL_LO+:3];
      assign burst = cmr[`TCC_CMR_BURST_LO+:2];

      always_comb begin
        case (tcc_pkg::tcc_clksel_t'(clkSel))
          tcc_pkg::TCC_CLK_DIV2: selLvl = divLvl[0];
          tcc_pkg::TCC_CLK_DIV8: selLvl = divLvl[1];
          tcc_pkg::TCC_CLK_DIV32: selLvl = divLvl[2];
          tcc_pkg::TCC_CLK_DIV128: selLvl = divLvl[3];
          tcc_pkg::TCC_CLK_SLOW: selLvl = slowLvl;
          tcc_pkg::TCC_CLK_XC0: selLvl = xc[0];
          tcc_pkg::TCC_CLK_XC1: selLvl = xc[1];
          tcc_pkg::TCC_CLK_XC2: selLvl = xc[2];
          default: selLvl = 1'b0;
        endcase
      end

      // external clocks are only resolved if slower than the master clock
      assign gateLvl = (selLvl ^ cmr[`TCC_CMR_CLOCK_INVERT_BIT])
                       & ((burst == 2'h0) | xc[burst - 2'h1]);
      assign tick = gateLvl & ~gatePrev_q;
      assign counting = tick && clkOn_q[gc] && running_q && !trgPend_q;
      assign overflow = counting && (cv_q[gc] == `TCC_CV_MAX);

      // compare C is edge detected so a stalled counter raises it once
      assign match = (cv_q[gc] == rc_q[gc]);
      assign cpcEvt = match && !match_q;

      // external trigger: line A or B in capture, event source in waveform
      always_comb begin
        if (!wave) begin
          extEvt = cmr[`TCC_CMR_TRIGGER_SOURCE_BIT]
                   ? edgeHit(cmr[`TCC_CMR_TRIGGER_EDGE_FIELD_LO+:2], aInRise[gc], aInFall[gc])
                   : edgeHit(cmr[`TCC_CMR_TRIGGER_EDGE_FIELD_LO+:2], bInRise[gc], bInFall[gc]);
        end else begin
          case (cmr[`TCC_CMR_EEVT_LO+:2])
            2'h0: extEvt = edgeHit(cmr[`TCC_CMR_TRIGGER_EDGE_FIELD_LO+:2], bInRise[gc], bInFall[gc]);
            2'h1: extEvt = edgeHit(cmr[`TCC_CMR_TRIGGER_EDGE_FIELD_LO+:2], xc[0] & ~gatePrevXc[0],
                                   ~xc[0] & gatePrevXc[0]);
            2'h2: extEvt = edgeHit(cmr[`TCC_CMR_TRIGGER_EDGE_FIELD_LO+:2], xc[1] & ~gatePrevXc[1],
                                   ~xc[1] & gatePrevXc[1]);
            default: extEvt = edgeHit(cmr[`TCC_CMR_TRIGGER_EDGE_FIELD_LO+:2], xc[2] & ~gatePrevXc[2],
                                      ~xc[2] & gatePrevXc[2]);
          endcase
        end
      end
      assign extTrg = extEvt && (!wave || cmr[`TCC_CMR_EXTERNAL_EVENT_TRIGGER_ENABLE]);
      assign software_trigger_bit = ccrWr && regWdata[`TCC_CCR_SOFTWARE_TRIGGER_BIT];
      assign trig = software_trigger_bit || syncPulse || extTrg
                    || (cpcEvt && cmr[`TCC_CMR_COMPARE_C_TRIGGER]);

      // capture loads alternate A then B between triggers
      assign loadA = !wave && !expectB_q
                     && edgeHit(cmr[`TCC_CMR_LOAD_A_EDGE_LO+:2], aInRise[gc], aInFall[gc]);
      assign loadB = !wave && expectB_q
                     && edgeHit(cmr[`TCC_CMR_LOAD_B_EDGE_LO+:2], aInRise[gc], aInFall[gc]);

      assign stopEvt = wave ? (cpcEvt && cmr[`TCC_CMR_COMPARE_C_STOP])
                            : (loadB && cmr[`TCC_CMR_LOAD_B_STOP]);
      assign disEvt = wave ? (cpcEvt && cmr[`TCC_CMR_COMPARE_C_DISABLE])
                           : (loadB && cmr[`TCC_CMR_LOAD_B_DISABLE]);
      // an enable written together with a trigger lets that trigger start
      assign enNow = (clkOn_q[gc] || (ccrWr && regWdata[`TCC_CCR_CLOCK_ENABLE_CMD]))
                     && !(ccrWr && regWdata[`TCC_CCR_CLOCK_DISABLE_CMD]);

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          cmr_q[gc] <= `TCC_CMR_RESET;
        end else if (clock_enable_cmd && cmrWr) begin
          cmr_q[gc] <= regWdata[`TCC_CMR_WIDTH-1:0];
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          gatePrev_q <= 1'b0;
          match_q <= 1'b0;
        end else if (clock_enable_cmd) begin
          gatePrev_q <= gateLvl;
          match_q <= match;
        end
      end

      // disable wins over enable when both arrive together
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          clkOn_q[gc] <= 1'b0;
          running_q <= 1'b0;
        end else if (clock_enable_cmd) begin
          if ((ccrWr && regWdata[`TCC_CCR_CLOCK_DISABLE_CMD]) || disEvt) begin
            clkOn_q[gc] <= 1'b0;
          end else if (ccrWr && regWdata[`TCC_CCR_CLOCK_ENABLE_CMD]) begin
            clkOn_q[gc] <= 1'b1;
          end
          if (enNow) begin
            if (trig) begin
              running_q <= 1'b1;
            end else if (stopEvt) begin
              running_q <= 1'b0;
            end
          end
        end
      end

      // trigger is held until the next active edge of the selected clock
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          trgPend_q <= 1'b0;
          cv_q[gc] <= `TCC_CV_RESET;
        end else if (clock_enable_cmd) begin
          if (trig) begin
            trgPend_q <= 1'b1;
          end else if (tick && clkOn_q[gc]) begin
            trgPend_q <= 1'b0;
          end
          // a disabled counter clock has no edges, so the trigger waits
          if (tick && trgPend_q && clkOn_q[gc]) begin
            cv_q[gc] <= `TCC_CV_RESET;
          end else if (counting) begin
            cv_q[gc] <= cv_q[gc] + 16'h0001;
          end
        end
      end

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          expectB_q <= 1'b0;
          ra_q[gc] <= `TCC_CV_RESET;
          rb_q[gc] <= `TCC_CV_RESET;
          rc_q[gc] <= `TCC_CV_RESET;
        end else if (clock_enable_cmd) begin
          if (trig) begin
            expectB_q <= 1'b0;
          end else if (loadA) begin
            expectB_q <= 1'b1;
          end else if (loadB) begin
            expectB_q <= 1'b0;
          end
          if (loadA) begin
            ra_q[gc] <= cv_q[gc];
          end else if (wave && regWr && chSel && regAddr[5:0] == `TCC_OFS_RA) begin
            ra_q[gc] <= regWdata[15:0];
          end
          if (loadB) begin
            rb_q[gc] <= cv_q[gc];
          end else if (wave && regWr && chSel && regAddr[5:0] == `TCC_OFS_RB) begin
            rb_q[gc] <= regWdata[15:0];
          end
          if (regWr && chSel && regAddr[5:0] == `TCC_OFS_RC) begin
            rc_q[gc] <= regWdata[15:0];
          end
        end
      end

      // a new load wins over a read in the same cycle
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          raUnread_q <= 1'b0;
          rbUnread_q <= 1'b0;
        end else if (clock_enable_cmd) begin
          if (loadA) begin
            raUnread_q <= 1'b1;
          end else if (regRd && chSel && regAddr[5:0] == `TCC_OFS_RA) begin
            raUnread_q <= 1'b0;
          end
          if (loadB) begin
            rbUnread_q <= 1'b1;
          end else if (regRd && chSel && regAddr[5:0] == `TCC_OFS_RB) begin
            rbUnread_q <= 1'b0;
          end
        end
      end

      always_comb begin
        setFlags = '0;
        setFlags[`TCC_SR_COUNTER_OVERFLOW_FLAG] = overflow;
        setFlags[`TCC_SR_LOAD_OVERRUN_FLAG] = (loadA && raUnread_q) || (loadB && rbUnread_q);
        setFlags[`TCC_SR_CPCS] = cpcEvt;
        setFlags[`TCC_SR_LDRAS] = loadA;
        setFlags[`TCC_SR_LDRBS] = loadB;
        setFlags[`TCC_SR_ETRGS] = extEvt;
      end

      // flags clear on status read; a set in that same cycle survives
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          sr_q[gc] <= '0;
          imr_q[gc] <= '0;
        end else if (clock_enable_cmd) begin
          sr_q[gc] <= (srRead ? '0 : sr_q[gc]) | setFlags;
          if (regWr && chSel && regAddr[5:0] == `TCC_OFS_IER) begin
            imr_q[gc] <= imr_q[gc] | regWdata[`TCC_SR_FLAGS-1:0];
          end else if (regWr && chSel && regAddr[5:0] == `TCC_OFS_IDR) begin
            imr_q[gc] <= imr_q[gc] & ~regWdata[`TCC_SR_FLAGS-1:0];
          end
        end
      end

      // waveform generation lives elsewhere; line A drives a quiet low here
      assign lineAOutLvl[gc] = 1'b0;

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          ioLineAOut[gc] <= 1'b0;
          ioLineAOe[gc] <= 1'b0;
          ioLineBOut[gc] <= 1'b0;
          ioLineBOe[gc] <= 1'b0;
          chanIrq[gc] <= 1'b0;
        end else if (clock_enable_cmd) begin
          ioLineAOut[gc] <= lineAOutLvl[gc];
          ioLineAOe[gc] <= wave;
          ioLineBOut[gc] <= 1'b0;
          ioLineBOe[gc] <= wave && (cmr[`TCC_CMR_EEVT_LO+:2] != 2'h0);
          chanIrq[gc] <= |(sr_q[gc] & imr_q[gc]);
        end
      end
    end
  endgenerate

  // previous external clock line levels for waveform event edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gatePrevXc <= '0;
    end else if (clock_enable_cmd) begin
      gatePrevXc <= xc;
    end
  end

  // read path: data stand in the cycle after the strobe only
  logic [31:0] rdMux;
  logic [1:0] rch;
  assign rch = regAddr[7:6];
  always_comb begin
    rdMux = 32'h00000000;
    if (regAddr == `TCC_OFS_BMR) begin
      rdMux = {26'h0000000, bmr_q};
    end else if (rch != 2'h3) begin
      case (regAddr[5:0])
        `TCC_OFS_CMR: rdMux = {12'h000, cmr_q[rch]};
        `TCC_OFS_CV: rdMux = {16'h0000, cv_q[rch]};
        `TCC_OFS_RA: rdMux = {16'h0000, ra_q[rch]};
        `TCC_OFS_RB: rdMux = {16'h0000, rb_q[rch]};
        `TCC_OFS_RC: rdMux = {16'h0000, rc_q[rch]};
        `TCC_OFS_SR: begin
          rdMux[`TCC_SR_FLAGS-1:0] = sr_q[rch];
          rdMux[`TCC_SR_CLOCK_ENABLED_FLAG] = clkOn_q[rch];
        end
        `TCC_OFS_IMR: rdMux = {24'h000000, imr_q[rch]};
        default: rdMux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h00000000;
    end else if (clock_enable_cmd) begin
      regRdata <= regRd ? rdMux : 32'h00000000;
    end
  end

endmodule : tcc_timer_block
`default_nettype wire

/* dv/tcc_pin_model.sv */
/*
 Pin-side model: external clock pin 0, line A and B levels, slow clock.
 Assumes its tasks are called by the bench just after a sys_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  input wire logic sys_clk,
  output logic slowClock,
  output logic [2:0] extClockPin,
  output logic [2:0] ioLineAIn,
  output logic [2:0] ioLineBIn
);
  logic [4:0] slowCnt;
  // line B rests low on its pull-down; clock pins stand still outside bursts
  initial begin
    slowCnt = 5'h00;
    slowClock = 1'b0;
    extClockPin = 3'h0;
    ioLineAIn = 3'h0;
    ioLineBIn = 3'h0;
  end
  // slow clock runs free, period 64 master cycles
  always @(posedge sys_clk) begin
    slowCnt <= slowCnt + 5'h01;
    if (slowCnt == 5'h1F) begin
      slowClock <= ~slowClock;
    end
  end
  // 4 cycles per level: above one period and below a 2.5x rate
  task automatic extEdges(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      extClockPin[0] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      extClockPin[0] <= 1'b0;
    end
    // let the last edge pass the filter before the caller reads
    repeat (8) @(posedge sys_clk);
  endtask : extEdges
  // all lines B at once; only channel 0 arms a line B trigger
  task automatic pulseB(input int w);
    ioLineBIn <= 3'h7;
    repeat (w) @(posedge sys_clk);
    ioLineBIn <= 3'h0;
    repeat (w) @(posedge sys_clk);
  endtask : pulseB
  // pulse far wider than one master period so the filter keeps it
  task automatic pulseA(input int w);
    ioLineAIn[0] <= 1'b1;
    repeat (w) @(posedge sys_clk);
    ioLineAIn[0] <= 1'b0;
    repeat (w) @(posedge sys_clk);
  endtask : pulseA
endmodule : tcc_pin_model
`default_nettype wire

/* dv/tcc_timer_block_monitor.sv */
/*
 Port checker for tcc_timer_block, channel 0 view.
 Assumes one clock sys_clk; bound into the design below.
*/
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_block_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clock_enable_cmd,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [2:0] ioLineAOut,
  input wire logic [2:0] ioLineAOe,
  input wire logic [2:0] ioLineBOut,
  input wire logic [2:0] ioLineBOe,
  input wire logic [2:0] chanIrq
);
  logic aOe_q, bOe_q, en_q;
  logic [7:0] mask_q;
  wire logic wr = regWr && clock_enable_cmd;
  wire logic rd = regRd && clock_enable_cmd;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aOe_q <= 1'b0;
      bOe_q <= 1'b0;
    end else if (wr && regAddr == 8'h04) begin
      aOe_q <= regWdata[15];
      bOe_q <= regWdata[15] && regWdata[11:10] != 2'h0;
    end
  end
  // disable wins over enable in one write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
    end else if (wr && regAddr == 8'h00 && regWdata[1:0] != 2'h0) begin
      en_q <= !regWdata[1];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= 8'h00;
    end else if (wr && regAddr == 8'h24) begin
      mask_q <= mask_q | regWdata[7:0];
    end else if (wr && regAddr == 8'h28) begin
      mask_q <= mask_q & ~regWdata[7:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  read_idle_a: assert property (clock_enable_cmd && !regRd |=> regRdata == 32'h0)
    else $error("read data outside read slot");
  cv_width_a: assert property (rd && regAddr == 8'h10 |=> regRdata[31:16] == 16'h0)
    else $error("counter wider than 16 bits");
  lines_low_a: assert property (ioLineAOut == 3'h0 && ioLineBOut == 3'h0)
    else $error("line drive value not low");
  line_a_dir_a: assert property ($past(aOe_q) == aOe_q && $past(aOe_q, 2) == aOe_q
    |-> ioLineAOe[0] == aOe_q)
    else $error("line A direction wrong");
  line_b_dir_a: assert property ($past(bOe_q) == bOe_q && $past(bOe_q, 2) == bOe_q
    |-> ioLineBOe[0] == bOe_q)
    else $error("line B direction wrong");
  irq_masked_a: assert property (mask_q == 8'h0 && $past(mask_q) == 8'h0
    |-> !chanIrq[0])
    else $error("interrupt with empty mask");
  clk_off_a: assert property (rd && regAddr == 8'h20 && !en_q && !$past(en_q)
    |=> !regRdata[16])
    else $error("clock flag set while disabled");
  reset_out_a: assert property ($rose(rst_n) |-> chanIrq == 3'h0 && ioLineAOe == 3'h0)
    else $error("outputs not low after reset");
  cover property (rd && regAddr == 8'h14);
  cover property (chanIrq[0]);
  cover property (ioLineBOe[0]);
endmodule : tcc_timer_block_monitor
bind tcc_timer_block tcc_timer_block_monitor u_tcc_timer_block_monitor (
  .sys_clk(sys_clk), .rst_n(rst_n), .clock_enable_cmd(clock_enable_cmd), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .ioLineAOut(ioLineAOut), .ioLineAOe(ioLineAOe), .ioLineBOut(ioLineBOut),
  .ioLineBOe(ioLineBOe), .chanIrq(chanIrq));
`default_nettype wire

/* dv/tcc_timer_block_test.sv */
/*
 Self-checking bench for tcc_timer_block over its register port.
 Assumes the pin model on the far side; clock_enable_cmd high except for one gating window.
*/
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_block_test;
  logic sys_clk, rst_n, clock_enable_cmd, regWr, regRd;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, v, a;
  logic slowClock;
  logic [2:0] extClockPin, ioLineAIn, ioLineBIn, aOut, aOe, bOut, bOe, chanIrq;
  int badCount, nChecks, cycles, w;
  tcc_timer_block u_tcc_timer_block (.sys_clk(sys_clk), .rst_n(rst_n), .clock_enable_cmd(clock_enable_cmd),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .slowClock(slowClock), .extClockPin(extClockPin),
    .ioLineAIn(ioLineAIn), .ioLineAOut(aOut), .ioLineAOe(aOe), .ioLineBIn(ioLineBIn),
    .ioLineBOut(bOut), .ioLineBOe(bOe), .chanIrq(chanIrq));
  tcc_pin_model u_tcc_pin_model (.sys_clk(sys_clk), .slowClock(slowClock),
    .extClockPin(extClockPin), .ioLineAIn(ioLineAIn), .ioLineBIn(ioLineBIn));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= ad;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic inr(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    nChecks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      badCount++;
      $display("wrong value at %0t: got %h want %h..%h", $time, g, lo, hi);
    end
  endtask : inr
  task automatic testDone;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : testDone
  // ceiling well above the roughly 4700 cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      badCount++;
      testDone();
    end
  end
  initial begin
    {rst_n, regWr, regRd, regAddr, regWdata} = '0;
    clock_enable_cmd = 1'b1;
    {badCount, nChecks, cycles} = '0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h04, v);
    inr(v, 0, 0);
    rd(8'h10, v);
    inr(v, 0, 0);
    rd(8'h08, v);
    inr(v, 0, 0);
    $display("test reset done");
    for (int s = 0; s < 5; s++) begin
      w = (s == 4) ? 64 : 2 << (2 * s);
      wr(8'h04, 32'(s));
      wr(8'h00, 32'h5);
      repeat (16 * w) @(posedge sys_clk);
      rd(8'h10, v);
      inr(v, 13, 17);
    end
    wr(8'h04, 32'h5);
    wr(8'h00, 32'h5);
    u_tcc_pin_model.extEdges(10);
    rd(8'h10, v);
    inr(v, 9, 9);
    wr(8'h04, 32'hD);
    wr(8'h00, 32'h5);
    u_tcc_pin_model.extEdges(10);
    rd(8'h10, a);
    inr(a, 9, 9);
    wr(8'h00, 32'h4);
    wr(8'hC4, 32'h1);
    u_tcc_pin_model.extEdges(4);
    rd(8'h10, v);
    inr(v, a, a);
    wr(8'hC4, 32'h0);
    wr(8'h04, 32'h10);
    wr(8'h00, 32'h5);
    repeat (40) @(posedge sys_clk);
    rd(8'h10, v);
    inr(v, a, a);
    $display("test clocks done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h2);
    rd(8'h10, a);
    wr(8'h00, 32'h4);
    repeat (20) @(posedge sys_clk);
    rd(8'h10, v);
    inr(v, a, a);
    rd(8'h20, v);
    inr(v[16], 0, 0);
    wr(8'h00, 32'h1);
    rd(8'h20, v);
    inr(v[16], 1, 1);
    wr(8'h40, 32'h1);
    wr(8'hC0, 32'h1);
    repeat (32) @(posedge sys_clk);
    rd(8'h50, v);
    inr(v, 13, 17);
    rd(8'h50, a);
    @(posedge sys_clk);
    clock_enable_cmd <= 1'b0;
    repeat (40) @(posedge sys_clk);
    clock_enable_cmd <= 1'b1;
    rd(8'h50, v);
    inr(v - a, 1, 2);
    $display("test gating done");
    wr(8'h04, 32'h90000);
    wr(8'h24, 32'h20);
    wr(8'h00, 32'h5);
    u_tcc_pin_model.pulseA(20);
    inr(chanIrq[0], 1, 1);
    rd(8'h14, a);
    rd(8'h18, v);
    inr(v - a, 10, 10);
    rd(8'h20, v);
    inr(v & 32'h62, 32'h60, 32'h60);
    repeat (3) @(posedge sys_clk);
    inr(chanIrq[0], 0, 0);
    u_tcc_pin_model.pulseA(20);
    u_tcc_pin_model.pulseA(20);
    rd(8'h20, v);
    inr(v & 32'h62, 32'h62, 32'h62);
    wr(8'h04, 32'h90080);
    wr(8'h00, 32'h5);
    u_tcc_pin_model.pulseA(20);
    rd(8'h20, v);
    inr(v[16], 0, 0);
    $display("test capture done");
    wr(8'h04, 32'h8400);
    repeat (4) @(posedge sys_clk);
    inr({aOe[0], bOe[0]}, 3, 3);
    wr(8'h1C, 32'h5);
    wr(8'h04, 32'hC000);
    wr(8'h00, 32'h5);
    repeat (100) @(posedge sys_clk);
    inr({aOe[0], bOe[0]}, 2, 2);
    rd(8'h10, v);
    inr(v, 0, 5);
    wr(8'h04, 32'h100);
    wr(8'h00, 32'h5);
    repeat (200) @(posedge sys_clk);
    u_tcc_pin_model.pulseB(20);
    rd(8'h10, v);
    inr(v, 17, 17);
    $display("test modes done");
    testDone();
  end
endmodule : tcc_timer_block_test
`default_nettype wire
